/* common/twb_params.svh */
/*
  constants of the two-wire bus master: timing, packet layout, addresses.
  assumes a 125 MHz system clock; included by the core only.
*/
// Contract
// - data stable while clock high, except start/stop
// - start/stop are sda changes with scl high
// - start opens, stop closes; bus busy between
// - start before stop is a repeated start
// - address packet: seven address, direction, acknowledge
// - direction one reads, zero writes
// - addressed slave pulls sda low in ninth
// - busy slave leaves sda high; stop or restart
// - address byte goes out msb first
// - all-zero address is general call, write only
// - never send general call with read bit
// - addresses 1111xxx stay reserved, never used
// - data packet: eight data bits plus acknowledge
// - master clocks; receiver alone sends acknowledge
// - acknowledge drives sda low, nack leaves high
// - receiver nacks the last byte it takes
// - data bytes go out msb first
// - no start directly followed by stop
// - slave may stretch clock low, not high
// - power gate cleared before interface operates
// - master checks sda each bit, yields on mismatch
`ifndef TWB_PARAMS_SVH
`define TWB_PARAMS_SVH
// system clock period and scl half period, in ns
`define TWB_CLK_NS      8
`define TWB_HALF_NS     5000
// half period in cycles, least time so rounded up
`define TWB_HALF_CYC    ((`TWB_HALF_NS + `TWB_CLK_NS - 1) / `TWB_CLK_NS)
// timer width
`define TWB_TMR_W       16
// index of the acknowledge bit inside a nine-bit packet
`define TWB_PKT_LAST    4'h8
// first bit index of a packet
`define TWB_PKT_FIRST   4'h0
// general call address and reserved upper nibble
`define TWB_GCALL_ADDR  7'h00
`define TWB_RSVD_HI     4'hf
// released level and all-ones read filler
`define TWB_REL_BYTE    8'hff
`endif

/* common/twb_pkg.sv */
/*
  types of the two-wire bus master: states, commands, responses.
  assumes nothing beyond a systemverilog compiler.
*/
package twb_pkg;
  // engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_RS_A, ST_START_W, ST_START_H, ST_START_B,
    ST_LOW_A, ST_LOW_B, ST_HIGH_W, ST_HIGH, ST_HOLD,
    ST_STOP_A, ST_STOP_W, ST_STOP_H, ST_STOP_C
  } twb_state_e;
  // user commands
  typedef enum logic [1:0] {
    OP_START, OP_WRITE, OP_READ, OP_STOP
  } twb_op_e;
  // command: data holds {address, direction} for a start
  typedef struct packed {
    twb_op_e    op;
    logic [7:0] data;
    logic       nack;
  } twb_cmd_s;
  // response to every accepted command
  typedef struct packed {
    logic [7:0] data;
    logic       acked;
    logic       arb_lost;
    logic       err;
  } twb_rsp_s;
endpackage

/* core/twb_master.sv */
/*
  two-wire bus master: start, repeated start, stop, nine-bit packets,
  acknowledge, arbitration loss and clock stretching on open-drain pins.
  assumes pull-ups outside; scl_i/sda_i are raw pin levels; commands
  come from logic on clock_i.
*/
`timescale 1ns/10ps
`include "twb_params.svh"
module twb_master #(
  parameter int unsigned HALF_CYC = `TWB_HALF_CYC
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  // power gate
  input  wire logic              enable_i,
  output logic                   two_wire_power_gate_o,
  // command port
  input  wire logic              cmd_valid_i,
  input  wire twb_pkg::twb_cmd_s cmd_i,
  output logic                   cmd_ready_o,
  // response port
  output logic                   rsp_valid_o,
  output twb_pkg::twb_rsp_s      rsp_o,
  // bus status
  output logic                   bus_busy_o,
  // scl pin
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_n_o,
  // sda pin
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n_o
);
  localparam int unsigned QTR_CYC = HALF_CYC / 2;
  localparam logic [`TWB_TMR_W-1:0] HALF_LD = `TWB_TMR_W'(HALF_CYC - 1);
  localparam logic [`TWB_TMR_W-1:0] QTR_LD  = `TWB_TMR_W'(QTR_CYC - 1);

  // reserved or meaningless start address
  function automatic logic bad_addr(input logic [7:0] a);
    bad_addr = (a[7:4] == `TWB_RSVD_HI) ||
               (a[7:1] == `TWB_GCALL_ADDR && a[0]);
  endfunction

  logic       scl_s;        // synchronised scl
  logic       sda_s;        // synchronised sda
  logic       scl_p_r;      // previous scl_s
  logic       sda_p_r;      // previous sda_s
  logic       busy_r;       // bus busy between start and stop
  logic       scl_p_nxt;
  logic       sda_p_nxt;
  logic       busy_nxt;
  logic       tmr_ld;       // timer load strobe
  logic [`TWB_TMR_W-1:0] tmr_val;  // timer load value
  logic       tmr_done;     // phase over

  twb_pkg::twb_state_e state_r, state_nxt;        // engine state
  logic [8:0] sh_r, sh_nxt;                       // outgoing packet
  logic [7:0] rx_r, rx_nxt;                       // incoming byte
  logic [3:0] bit_r, bit_nxt;                     // bit index 0..8
  logic       tx_r, tx_nxt;                       // we send the byte
  logic       addr_r, addr_nxt;                   // packet is address
  logic       ddone_r, ddone_nxt;                 // data packet seen
  logic       anack_r, anack_nxt;                 // address was nacked
  logic       scl_pull_r, scl_pull_nxt;           // pulling scl low
  logic       sda_pull_r, sda_pull_nxt;           // pulling sda low
  logic       gate_r, gate_nxt;                   // power gate
  logic       rsp_v_r, rsp_v_nxt;                 // response strobe
  twb_pkg::twb_rsp_s rsp_r, rsp_nxt;              // response data
  logic       own_c;        // this bit is driven by us
  logic       arb_c;        // arbitration lost this bit
  logic       fire;         // command taken

  // pin synchroniser
  twb_sync #(.W(2)) u_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .d_i     ({scl_i, sda_i}),
    .q_o     ({scl_s, sda_s})
  );

  // phase timer, also the scl divider
  twb_timer #(.W(`TWB_TMR_W)) u_tmr (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .load_i  (tmr_ld),
    .value_i (tmr_val),
    .done_o  (tmr_done)
  );

  // bus monitor: start sets busy, stop clears it
  always_comb begin
    scl_p_nxt = scl_s;
    sda_p_nxt = sda_s;
    busy_nxt  = busy_r;
    if (scl_s && scl_p_r && sda_p_r && !sda_s) begin
      busy_nxt = 1'b1;
    end else if (scl_s && scl_p_r && !sda_p_r && sda_s) begin
      busy_nxt = 1'b0;
    end
  end

  // bus monitor registers
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      scl_p_r <= scl_p_nxt;
      sda_p_r <= sda_p_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // command acceptance: wait for a free bus, refuse an empty message
  always_comb begin
    cmd_ready_o = 1'b0;
    if (!gate_r) begin
      if (state_r == twb_pkg::ST_IDLE) begin
        cmd_ready_o = (cmd_i.op != twb_pkg::OP_START) || !busy_r;
      end else if (state_r == twb_pkg::ST_HOLD) begin
        cmd_ready_o = (cmd_i.op != twb_pkg::OP_STOP) ||
                      ddone_r || anack_r;
      end
    end
  end
  assign fire  = cmd_valid_i && cmd_ready_o;
  assign own_c = tx_r ? (bit_r != `TWB_PKT_LAST)
                      : (bit_r == `TWB_PKT_LAST);
  assign arb_c = own_c && !sda_pull_r && !sda_s;

  // engine next state
  always_comb begin
    state_nxt    = state_r;
    sh_nxt       = sh_r;
    rx_nxt       = rx_r;
    bit_nxt      = bit_r;
    tx_nxt       = tx_r;
    addr_nxt     = addr_r;
    ddone_nxt    = ddone_r;
    anack_nxt    = anack_r;
    scl_pull_nxt = scl_pull_r;
    sda_pull_nxt = sda_pull_r;
    gate_nxt     = !enable_i;
    rsp_v_nxt    = 1'b0;
    rsp_nxt      = rsp_r;
    tmr_ld       = 1'b0;
    tmr_val      = QTR_LD;
    case (state_r)
      twb_pkg::ST_IDLE, twb_pkg::ST_HOLD: begin
        if (fire) begin
          rsp_nxt = '0;
          case (cmd_i.op)
            twb_pkg::OP_START: begin
              if (bad_addr(cmd_i.data)) begin
                rsp_v_nxt   = 1'b1;
                rsp_nxt.err = 1'b1;
              end else begin
                // address then direction, released acknowledge
                sh_nxt       = {cmd_i.data, 1'b1};
                tx_nxt       = 1'b1;
                addr_nxt     = 1'b1;
                ddone_nxt    = 1'b0;
                anack_nxt    = 1'b0;
                sda_pull_nxt = 1'b0;
                tmr_ld       = 1'b1;
                state_nxt    = twb_pkg::ST_RS_A;
              end
            end
            twb_pkg::OP_WRITE: begin
              if (state_r == twb_pkg::ST_IDLE) begin
                rsp_v_nxt   = 1'b1;
                rsp_nxt.err = 1'b1;
              end else begin
                sh_nxt    = {cmd_i.data, 1'b1};
                tx_nxt    = 1'b1;
                bit_nxt   = `TWB_PKT_FIRST;
                tmr_ld    = 1'b1;
                state_nxt = twb_pkg::ST_LOW_A;
              end
            end
            twb_pkg::OP_READ: begin
              if (state_r == twb_pkg::ST_IDLE) begin
                rsp_v_nxt   = 1'b1;
                rsp_nxt.err = 1'b1;
              end else begin
                sh_nxt    = {`TWB_REL_BYTE, cmd_i.nack};
                tx_nxt    = 1'b0;
                bit_nxt   = `TWB_PKT_FIRST;
                tmr_ld    = 1'b1;
                state_nxt = twb_pkg::ST_LOW_A;
              end
            end
            default: begin
              if (state_r == twb_pkg::ST_IDLE) begin
                rsp_v_nxt   = 1'b1;
                rsp_nxt.err = 1'b1;
              end else begin
                sda_pull_nxt = 1'b1;
                tmr_ld       = 1'b1;
                state_nxt    = twb_pkg::ST_STOP_A;
              end
            end
          endcase
        end
      end
      // sda released while scl low (or idle high), then release scl
      twb_pkg::ST_RS_A: begin
        if (tmr_done) begin
          scl_pull_nxt = 1'b0;
          state_nxt    = twb_pkg::ST_START_W;
        end
      end
      // wait until scl is really high
      twb_pkg::ST_START_W: begin
        if (scl_s) begin
          tmr_ld    = 1'b1;
          tmr_val   = HALF_LD;
          state_nxt = twb_pkg::ST_START_H;
        end
      end
      // start: sda falls while scl high
      twb_pkg::ST_START_H: begin
        if (tmr_done) begin
          sda_pull_nxt = 1'b1;
          tmr_ld       = 1'b1;
          tmr_val      = HALF_LD;
          state_nxt    = twb_pkg::ST_START_B;
        end
      end
      twb_pkg::ST_START_B: begin
        if (tmr_done) begin
          scl_pull_nxt = 1'b1;
          bit_nxt      = `TWB_PKT_FIRST;
          tmr_ld       = 1'b1;
          state_nxt    = twb_pkg::ST_LOW_A;
        end
      end
      // first half of low phase: sda may change only now
      twb_pkg::ST_LOW_A: begin
        if (tmr_done) begin
          sda_pull_nxt = !sh_r[8];
          tmr_ld       = 1'b1;
          state_nxt    = twb_pkg::ST_LOW_B;
        end
      end
      twb_pkg::ST_LOW_B: begin
        if (tmr_done) begin
          scl_pull_nxt = 1'b0;
          state_nxt    = twb_pkg::ST_HIGH_W;
        end
      end
      // a stretching slave or a flagged device keeps scl low here
      twb_pkg::ST_HIGH_W: begin
        if (scl_s) begin
          tmr_ld    = 1'b1;
          tmr_val   = HALF_LD;
          state_nxt = twb_pkg::ST_HIGH;
        end
      end
      // high phase: sample at its end, check arbitration
      twb_pkg::ST_HIGH: begin
        if (tmr_done) begin
          if (arb_c) begin
            sda_pull_nxt     = 1'b0;
            scl_pull_nxt     = 1'b0;
            rsp_v_nxt        = 1'b1;
            rsp_nxt.arb_lost = 1'b1;
            state_nxt        = twb_pkg::ST_IDLE;
          end else begin
            scl_pull_nxt = 1'b1;
            sh_nxt       = {sh_r[7:0], 1'b1};
            if (bit_r == `TWB_PKT_LAST) begin
              rsp_v_nxt     = 1'b1;
              rsp_nxt.data  = rx_r;
              rsp_nxt.acked = !sda_s;
              anack_nxt     = addr_r && sda_s;
              ddone_nxt     = ddone_r || !addr_r;
              addr_nxt      = 1'b0;
              state_nxt     = twb_pkg::ST_HOLD;
            end else begin
              rx_nxt    = {rx_r[6:0], sda_s};
              bit_nxt   = bit_r + 1'b1;
              tmr_ld    = 1'b1;
              state_nxt = twb_pkg::ST_LOW_A;
            end
          end
        end
      end
      // stop: sda low with scl low, then release scl
      twb_pkg::ST_STOP_A: begin
        if (tmr_done) begin
          scl_pull_nxt = 1'b0;
          state_nxt    = twb_pkg::ST_STOP_W;
        end
      end
      twb_pkg::ST_STOP_W: begin
        if (scl_s) begin
          tmr_ld    = 1'b1;
          tmr_val   = HALF_LD;
          state_nxt = twb_pkg::ST_STOP_H;
        end
      end
      // sda rises while scl high
      twb_pkg::ST_STOP_H: begin
        if (tmr_done) begin
          sda_pull_nxt = 1'b0;
          tmr_ld       = 1'b1;
          tmr_val      = HALF_LD;
          state_nxt    = twb_pkg::ST_STOP_C;
        end
      end
      // bus free time before answering
      twb_pkg::ST_STOP_C: begin
        if (tmr_done) begin
          rsp_v_nxt = 1'b1;
          rsp_nxt   = '0;
          state_nxt = twb_pkg::ST_IDLE;
        end
      end
      default: begin
        scl_pull_nxt = 1'b0;
        sda_pull_nxt = 1'b0;
        state_nxt    = twb_pkg::ST_IDLE;
      end
    endcase
  end

  // engine registers
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_r    <= twb_pkg::ST_IDLE;
      sh_r       <= '1;
      rx_r       <= '0;
      bit_r      <= `TWB_PKT_FIRST;
      tx_r       <= 1'b0;
      addr_r     <= 1'b0;
      ddone_r    <= 1'b0;
      anack_r    <= 1'b0;
      scl_pull_r <= 1'b0;
      sda_pull_r <= 1'b0;
      gate_r     <= 1'b1;
      rsp_v_r    <= 1'b0;
      rsp_r      <= '0;
    end else begin
      state_r    <= state_nxt;
      sh_r       <= sh_nxt;
      rx_r       <= rx_nxt;
      bit_r      <= bit_nxt;
      tx_r       <= tx_nxt;
      addr_r     <= addr_nxt;
      ddone_r    <= ddone_nxt;
      anack_r    <= anack_nxt;
      scl_pull_r <= scl_pull_nxt;
      sda_pull_r <= sda_pull_nxt;
      gate_r     <= gate_nxt;
      rsp_v_r    <= rsp_v_nxt;
      rsp_r      <= rsp_nxt;
    end
  end

  // outputs: open drain, enable low while pulling
  assign scl_o                 = 1'b0;
  assign sda_o                 = 1'b0;
  assign scl_oe_n_o            = !scl_pull_r;
  assign sda_oe_n_o            = !sda_pull_r;
  assign rsp_valid_o           = rsp_v_r;
  assign rsp_o                 = rsp_r;
  assign bus_busy_o            = busy_r;
  assign two_wire_power_gate_o = gate_r;

  // sda held through the whole high phase
  property p_sda_stable;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_r == twb_pkg::ST_HIGH) ##1 (state_r == twb_pkg::ST_HIGH)
      |-> $stable(sda_oe_n_o);
  endproperty
  a_sda_stable: assert property (p_sda_stable)
    else $error("sda changed while scl high");

  // start edge: sda falls with scl released
  property p_start_edge;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_r == twb_pkg::ST_START_H) && tmr_done
      |=> scl_oe_n_o && !sda_oe_n_o;
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("start not formed with scl high");

  // no start accepted on a busy bus from idle
  property p_busy_wait;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_r == twb_pkg::ST_IDLE) && busy_r &&
      (cmd_i.op == twb_pkg::OP_START) |-> !cmd_ready_o;
  endproperty
  a_busy_wait: assert property (p_busy_wait)
    else $error("start taken on busy bus");

  // a packet ends only after its ninth bit
  property p_nine_bits;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_r == twb_pkg::ST_HIGH) ##1 (state_r == twb_pkg::ST_HOLD)
      |-> $past(bit_r) == `TWB_PKT_LAST;
  endproperty
  a_nine_bits: assert property (p_nine_bits)
    else $error("packet not nine bits");

  // illegal addresses answered with error, no bus action
  property p_bad_addr;
    @(posedge clock_i) disable iff (!rstn_i)
    fire && (cmd_i.op == twb_pkg::OP_START) && bad_addr(cmd_i.data)
      |=> rsp_valid_o && rsp_o.err && (state_r == $past(state_r));
  endproperty
  a_bad_addr: assert property (p_bad_addr)
    else $error("reserved or read general call sent");

  // stop refused right after an acknowledged address
  property p_no_empty;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_r == twb_pkg::ST_HOLD) && !ddone_r && !anack_r &&
      (cmd_i.op == twb_pkg::OP_STOP) |-> !cmd_ready_o;
  endproperty
  a_no_empty: assert property (p_no_empty)
    else $error("empty message stop accepted");

  // high phase timed only from a seen-high scl
  property p_stretch;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_r == twb_pkg::ST_HIGH_W) ##1 (state_r == twb_pkg::ST_HIGH)
      |-> $past(scl_s);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("high phase started while scl low");

  // lost arbitration releases both lines and reports
  property p_arb;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_r == twb_pkg::ST_HIGH) && tmr_done && arb_c
      |=> sda_oe_n_o && scl_oe_n_o && rsp_valid_o && rsp_o.arb_lost;
  endproperty
  a_arb: assert property (p_arb)
    else $error("arbitration loss not handled");

  // read acknowledge bit driven low when ack requested
  property p_rd_ack;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_r == twb_pkg::ST_HIGH) && !tx_r &&
      (bit_r == `TWB_PKT_LAST) && !sh_r[8] |-> !sda_oe_n_o;
  endproperty
  a_rd_ack: assert property (p_rd_ack)
    else $error("receiver ack not driven");
endmodule

/* core/twb_sync.sv */
/*
  two flip-flop synchroniser for bus pin levels.
  assumes inputs are asynchronous levels; outputs are clock_i aligned.
*/
`timescale 1ns/10ps
module twb_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;  // first stage, read only by q_r
  logic [W-1:0] q_r;     // second stage
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // next values: shift through two stages
  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  // register; idle bus reads high
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      meta_r <= '1;
      q_r    <= '1;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule

/* core/twb_timer.sv */
/*
  phase timer: loads a count and reports when it has run down.
  assumes the loader holds load_i for one cycle per phase.
*/
`timescale 1ns/10ps
module twb_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  // control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              done_o
);
  logic [W-1:0] cnt_r;  // remaining cycles
  logic [W-1:0] cnt_nxt;

  // next count: load wins, else run down to zero
  always_comb begin
    if (load_i) begin
      cnt_nxt = value_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // register
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = (cnt_r == '0);
endmodule

/* testbench/twb_master_tb.sv */
/* self-checking bench of the two-wire master against a slave model.
   assumes twb_pkg and twb_master compiled first. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  err_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module twb_master_tb;
  localparam logic [6:0] SA = 7'h50;  // model address
  logic clock_i = 0, rstn_i = 0, enable_i = 0, cmd_valid_i = 0;
  twb_pkg::twb_cmd_s cmd_i = '0;
  twb_pkg::twb_rsp_s rsp_o, r;
  logic rsp_valid_o, cmd_ready_o, bus_busy_o, gate, scl_o, sda_o;
  logic m_scl, m_sda, s_scl, s_sda, w, tb_sda = 1, stretch = 0;
  logic [7:0] rd_byte = 8'h00, got;
  logic [6:0] a;
  logic [31:0] v, seed = 32'h00015a67;
  int err_count = 0, n_tests = 0;
  wire scl_w = (m_scl | scl_o) & s_scl;          // wired-and
  wire sda_w = (m_sda | sda_o) & s_sda & tb_sda;
  always #4 clock_i = ~clock_i;
  twb_master #(.HALF_CYC(8)) DUT (.clock_i, .rstn_i, .enable_i,
    .two_wire_power_gate_o(gate), .cmd_valid_i, .cmd_i, .cmd_ready_o,
    .rsp_valid_o, .rsp_o, .bus_busy_o, .scl_i(scl_w), .scl_o,
    .scl_oe_n_o(m_scl), .sda_i(sda_w), .sda_o, .sda_oe_n_o(m_sda));
  twb_slave_model #(.ADDR(SA)) SLV (.scl_i(scl_w), .sda_i(sda_w),
    .stretch_i(stretch), .rd_byte_i(rd_byte), .scl_oe_n_o(s_scl),
    .sda_oe_n_o(s_sda), .got_o(got));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // answered with err instead of sent
  function automatic logic bad(input logic [6:0] x, input logic y);
    return x[6:3] == 4'hf || (x == 7'h00 && y);
  endfunction
  // acked by the model
  function automatic logic hit(input logic [6:0] x, input logic y);
    return x == SA || (x == 7'h00 && !y);
  endfunction
  // offer a command, wait for take and answer
  task automatic cmd(input logic [1:0] op, input logic [7:0] d,
                     input logic nk);
    int k;
    k = 0;
    @(posedge clock_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= {op, d, nk};
    do @(negedge clock_i); while (cmd_ready_o !== 1'b1 && ++k < 4000);
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    do @(negedge clock_i); while (rsp_valid_o !== 1'b1 && ++k < 8000);
    if (k >= 8000) begin
      err_count++;
      $display("Error rsp_timeout expected %h seen %h", 1'b1, 1'b0);
    end
    r = rsp_o;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #640000;
    err_count++;
    $display("Error watchdog expected %h seen %h", 1'b1, 1'b0);
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(negedge clock_i);
    `CHK("gate", 1'b1, gate)
    `CHK("idle_lines", 2'b11, {m_scl, m_sda})
    `CHK("gate_ready", 1'b0, cmd_ready_o)
    `CHK("drive_low", 2'b00, {scl_o, sda_o})
    @(posedge clock_i);
    enable_i <= 1'b1;
    repeat (2) @(negedge clock_i);
    `CHK("gate", 1'b0, gate)
    cmd(2'd1, 8'h5a, 1'b0);
    `CHK("idle_write", 1'b1, r.err)
    cmd(2'd0, 8'hf1, 1'b0);
    `CHK("reserved", 1'b1, r.err)
    cmd(2'd0, 8'h01, 1'b0);
    `CHK("gcall_read", 1'b1, r.err)
    cmd(2'd2, 8'h00, 1'b0);
    `CHK("idle_read", 1'b1, r.err)
    cmd(2'd3, 8'h00, 1'b0);
    `CHK("idle_stop", 1'b1, r.err)
    $display("test refusals done");
    for (int t = 0; t < 24; t++) begin
      v = rnd();
      a = v[1:0] == 2'h0 ? 7'h00 : v[1] ? SA : v[8:2];
      w = v[9];
      stretch <= v[10];
      rd_byte <= v[18:11];
      cmd(2'd0, {a, w}, 1'b0);
      if (bad(a, w)) begin
        `CHK("bad_addr", 1'b1, r.err)
        continue;
      end
      `CHK("addr_ack", hit(a, w), r.acked)
      `CHK("busy", 1'b1, bus_busy_o)
      for (int i = 0; hit(a, w) && i <= int'(v[20:19]); i++) begin
        v[7:0] = 8'(rnd());
        cmd(w ? 2'd2 : 2'd1, w ? 8'hff : v[7:0], w && i == v[20:19]);
        if (w) `CHK("rd", rd_byte, r.data)
        else `CHK("wr", v[7:0], got)
        `CHK("dack", !(w && i == v[20:19]), r.acked)
      end
      repeat (20) @(negedge clock_i);
      `CHK("hold_scl", 1'b0, m_scl)
      if (v[21]) continue;
      cmd(2'd3, 8'h00, 1'b0);
      `CHK("stop", 1'b0, bus_busy_o)
    end
    $display("test random done");
    stretch <= 1'b0;
    cmd(2'd0, {SA, 1'b0}, 1'b0);
    @(posedge clock_i);
    tb_sda <= 1'b0;
    cmd_i.op <= twb_pkg::OP_STOP;
    @(negedge clock_i);
    `CHK("empty_stop", 1'b0, cmd_ready_o)
    cmd(2'd1, 8'hff, 1'b0);
    `CHK("arb_lost", 1'b1, r.arb_lost)
    `CHK("released", 2'b11, {m_scl, m_sda})
    @(posedge clock_i);
    cmd_i.op <= twb_pkg::OP_START;
    @(negedge clock_i);
    `CHK("busy_wait", 1'b0, cmd_ready_o)
    repeat (20) @(posedge clock_i);
    tb_sda <= 1'b1;
    repeat (20) @(negedge clock_i);
    `CHK("free", 1'b0, bus_busy_o)
    $display("test arbitration done");
    finish_test();
  end
endmodule

/* testbench/twb_slave_model.sv */
/* bus slave model: acks its own address and the general call, takes
   writes, sends reads, may stretch scl. assumes wired-and pull-ups. */
`timescale 1ns/10ps
module twb_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  // bus levels and control
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       stretch_i,
  input  wire logic [7:0] rd_byte_i,
  // open-drain enables, low pulls
  output logic            scl_oe_n_o,
  output logic            sda_oe_n_o,
  output logic [7:0]      got_o
);
  logic [7:0] sh = 8'h00;  // shift in
  logic [7:0] tx = 8'h00;  // shift out
  int         cnt = 0;     // rising edges in packet
  logic       adr = 1'b0;  // address packet next
  logic       sel = 1'b0;  // addressed
  logic       rd = 1'b0;   // read transfer
  logic       go = 1'b0;   // send a byte next
  logic       txo = 1'b0;  // sending
  initial scl_oe_n_o = 1'b1;
  initial sda_oe_n_o = 1'b1;
  initial got_o = 8'h00;
  // start and stop seen as sda edges with scl high
  always @(negedge sda_i) if (scl_i) begin
    cnt = 0;
    adr = 1'b1;
    sel = 1'b0;
    txo = 1'b0;
  end
  always @(posedge sda_i) if (scl_i) begin
    sel = 1'b0;
    txo = 1'b0;
  end
  // sample on rising scl, msb first
  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    else if (txo) go = !sda_i;
    cnt = cnt + 1;
  end
  // drive sda only while scl is low
  always @(negedge scl_i) begin
    if (cnt == 8) begin
      if (adr) begin
        sel = sh[7:1] == ADDR || sh == 8'h00;
        rd = sh[0];
        go = sel && rd;
      end else if (sel && !rd) got_o = sh;
      sda_oe_n_o = !(sel && (adr || !rd));
      adr = 1'b0;
    end else if (cnt == 9) begin
      cnt = 0;
      txo = go;
      tx = rd_byte_i;
      sda_oe_n_o = go ? tx[7] : 1'b1;
    end else if (txo) sda_oe_n_o = tx[7-cnt];
  end
  // stretch the low phase only
  always @(negedge scl_i) if (stretch_i) begin
    scl_oe_n_o = 1'b0;
    #200;
    scl_oe_n_o = 1'b1;
  end
endmodule
